//--- pkg/ndb_pkg.sv
// Constants, register map and carrier types of the data NVM byte access controller
// What this block does
// - Addressed byte lands in data register next cycle, unless a write is running
// - Data register holds until read or write
// - Unlock needs 55h then aa then write bit
// - Unlock sequence must take exact cycle count
// - Write bit blocked unless enable latch set
// - Enable latch changed only by software, power-up
// - Clearing enable latch never aborts running write
// - Completion clears write bit, sets done flag
// - Enable latch resets to zero
// - Power-up timer blocks all writes
package ndb_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	// Register offsets on the plain register port
	localparam logic [7:0] OFS_FLAGS    = 8'h0c;
	localparam logic [7:0] OFS_IRQ_EN   = 8'h8c;
	localparam logic [7:0] OFS_NVM_DATA = 8'h9a;
	localparam logic [7:0] OFS_NVM_ADDR = 8'h9b;
	localparam logic [7:0] OFS_NVM_CTRL = 8'h9c;
	localparam logic [7:0] OFS_UNLOCK   = 8'h9d;
	localparam logic [7:0] OFS_STATUS   = 8'h9e;
	// Control register bits
	localparam int unsigned CTRL_RD_BIT   = 0;
	localparam int unsigned CTRL_WR_BIT   = 1;
	localparam int unsigned CTRL_WRITE_ENABLE_LATCH_BIT = 2;
	localparam int unsigned CTRL_WRERR_BIT = 3;
	// Flag bit for write done
	localparam int unsigned FLAG_DONE_BIT = 7;
	localparam logic [7:0] FLAGS_RESET  = 8'h00;
	localparam logic [7:0] IRQ_EN_RESET = 8'h00;
	localparam logic [7:0] FLAGS_IMPL   = 8'h80;
	// Unlock keys
	localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
	localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
	// Cycles from key1 write to key2 write, and key2 write to write-bit set
	localparam logic [1:0] UNLOCK_GAP1 = 2'h2;
	localparam logic [1:0] UNLOCK_GAP2 = 2'h1;
	// Timing
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned PWRT_MS       = 72;
	localparam int unsigned PWRT_CYCLES   = (CLK_HZ / 1000) * PWRT_MS;
	localparam int unsigned WRITE_US      = 4000;
	localparam int unsigned WRITE_CYCLES  = (CLK_HZ / 1_000_000) * WRITE_US;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ndb_bus_req_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} ndb_mem_cmd_type;
endpackage

//--- verilog/ndb_cycle_timer.sv
// Down counter giving a done pulse after a programmable number of cycles
module ndb_cycle_timer #(
	parameter int unsigned CYCLES = 16
) (
	input  wire logic ref_clk_in,
	input  wire logic rst_n_in,
	input  wire logic start_in,
	output logic      busy_out,
	output logic      done_out
);
	localparam int unsigned CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LOAD = CW'(CYCLES);
	logic [CW-1:0] cnt_r;

	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			cnt_r    <= '0;
			busy_out <= 1'b0;
			done_out <= 1'b0;
		end
		else if (start_in && !busy_out)
		begin
			cnt_r    <= LOAD;
			busy_out <= 1'b1;
			done_out <= 1'b0;
		end
		else if (busy_out)
		begin
			cnt_r    <= cnt_r - CW'(1);
			busy_out <= (cnt_r != CW'(1));
			done_out <= (cnt_r == CW'(1));
		end
		else
		begin
			done_out <= 1'b0;
		end
	end
endmodule // ndb_cycle_timer

//--- verilog/ndb_byte_array.sv
// Byte array of the data memory, flip-flop storage
module ndb_byte_array #(
	parameter int unsigned DEPTH = 128
) (
	input  wire logic                    ref_clk_in,
	input  wire ndb_pkg::ndb_mem_cmd_type cmd_in,
	input  wire logic                    store_in,
	output logic [ndb_pkg::DATA_W-1:0]   rdata_out
);
	localparam int unsigned IW = $clog2(DEPTH);
	logic [ndb_pkg::DATA_W-1:0] mem_r [DEPTH];
	logic [IW-1:0]              idx;

	assign idx = cmd_in.addr[IW-1:0];
	// Contents survive reset, like real non-volatile cells
	always_ff @(posedge ref_clk_in)
	begin
		if (store_in)
		begin
			mem_r[idx] <= cmd_in.data;
		end
	end
	assign rdata_out = mem_r[idx];
endmodule // ndb_byte_array

//--- verilog/ndb_nvm_access.sv
// Data NVM byte access controller: registers, unlock check, write timing
//
// Local design decision: the address-and-strobe port.
module ndb_nvm_access #(
	parameter int unsigned PWRT_CYCLES  = ndb_pkg::PWRT_CYCLES,
	parameter int unsigned WRITE_CYCLES = ndb_pkg::WRITE_CYCLES,
	parameter int unsigned DEPTH        = 128
) (
	input  wire logic       ref_clk_in,
	input  wire logic       rst_n_in,
	input  wire logic [7:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	output logic [7:0]      reg_rdata_out,
	output logic            irq_out,
	output logic            write_busy_out
);
	typedef enum logic [1:0] {
		ndb_unlk_idle_type,
		ndb_unlk_key1_type,
		ndb_unlk_key2_type
	} ndb_unlk_state_type;

	ndb_pkg::ndb_bus_req_type req;
	ndb_pkg::ndb_mem_cmd_type cmd;
	ndb_pkg::ndb_mem_cmd_type cmd_r;
	ndb_unlk_state_type       unlk_r;
	logic [1:0]               gap_r;
	logic [7:0]               addr_r;
	logic [7:0]               data_r;
	logic                     write_enable_latch_r;
	logic                     wr_r;
	logic                     wrerr_r;
	logic                     done_flag_r;
	logic [6:0]               other_flags_r;
	logic [7:0]               irq_en_r;
	logic                     pwrt_busy;
	logic                     pwrt_arm_r;
	logic                     wr_busy;
	logic                     wr_done;
	logic                     start;
	logic                     wr_set_req;
	logic                     unlock_ok;
	logic [7:0]               mem_rdata;
	logic [7:0]               rd_nxt;
	logic [7:0]               ctrl_view;

	assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};
	// While a write runs, the array sees the address and byte captured at its start
	always_comb
	begin
		cmd = '{addr: addr_r, data: data_r};
		if (wr_r)
		begin
			cmd = cmd_r;
		end
	end

	// Capturing at start keeps later register writes from altering a write in flight
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			cmd_r <= '0;
		end
		else if (start)
		begin
			cmd_r <= '{addr: addr_r, data: data_r};
		end
	end

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	// One-shot start: a constant start would reload the lockout after every expiry
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			pwrt_arm_r <= 1'b1;
		end
		else
		begin
			pwrt_arm_r <= 1'b0;
		end
	end

	// Power-up lockout runs once after reset
	ndb_cycle_timer #(.CYCLES(PWRT_CYCLES)) u_pwrt (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (rst_n_in),
		.start_in   (pwrt_arm_r),
		.busy_out   (pwrt_busy),
		.done_out   ()
	);

	ndb_cycle_timer #(.CYCLES(WRITE_CYCLES)) u_wtime (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (rst_n_in),
		.start_in   (start),
		.busy_out   (wr_busy),
		.done_out   (wr_done)
	);

	ndb_byte_array #(.DEPTH(DEPTH)) u_array (
		.ref_clk_in (ref_clk_in),
		.cmd_in     (cmd),
		.store_in   (wr_done),
		.rdata_out  (mem_rdata)
	);

	// Software asks for the write bit on a control write with bit 1 set
	assign wr_set_req = req.wr && hit(req.addr, ndb_pkg::OFS_NVM_CTRL)
		&& req.wdata[ndb_pkg::CTRL_WR_BIT];
	assign unlock_ok = (unlk_r == ndb_unlk_key2_type)
		&& (gap_r == ndb_pkg::UNLOCK_GAP2);
	// Busy check stops a second start while one is running
	assign start = wr_set_req && write_enable_latch_r && unlock_ok && !pwrt_busy
		&& !wr_r;

	// Unlock sequencer; any other bus write or wrong timing drops back to idle
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			unlk_r <= ndb_unlk_idle_type;
			gap_r  <= 2'h0;
		end
		else
		begin
			if (gap_r != 2'h3)
			begin
				gap_r <= gap_r + 2'h1;
			end
			case (unlk_r)
				ndb_unlk_idle_type:
				begin
					if (req.wr && hit(req.addr, ndb_pkg::OFS_UNLOCK)
						&& req.wdata == ndb_pkg::UNLOCK_KEY1)
					begin
						unlk_r <= ndb_unlk_key1_type;
						gap_r  <= 2'h1;
					end
				end
				ndb_unlk_key1_type:
				begin
					if (req.wr && hit(req.addr, ndb_pkg::OFS_UNLOCK)
						&& req.wdata == ndb_pkg::UNLOCK_KEY2
						&& gap_r == ndb_pkg::UNLOCK_GAP1)
					begin
						unlk_r <= ndb_unlk_key2_type;
						gap_r  <= 2'h1;
					end
					else if (req.wr || gap_r >= ndb_pkg::UNLOCK_GAP1)
					begin
						unlk_r <= ndb_unlk_idle_type;
					end
				end
				ndb_unlk_key2_type:
				begin
					// One shot: whatever comes next ends the window
					if (req.wr || gap_r >= ndb_pkg::UNLOCK_GAP2)
					begin
						unlk_r <= ndb_unlk_idle_type;
					end
				end
				default:
				begin
					unlk_r <= ndb_unlk_idle_type;
				end
			endcase
		end
	end

	// Address register
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			addr_r <= 8'h00;
		end
		else if (req.wr && hit(req.addr, ndb_pkg::OFS_NVM_ADDR))
		begin
			addr_r <= req.wdata;
		end
	end

	// Data register: loaded by software or by a read, nothing else
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			data_r <= 8'h00;
		end
		else if (req.wr && hit(req.addr, ndb_pkg::OFS_NVM_DATA))
		begin
			data_r <= req.wdata;
		end
		else if (req.wr && hit(req.addr, ndb_pkg::OFS_NVM_CTRL)
			&& req.wdata[ndb_pkg::CTRL_RD_BIT] && !wr_r)
		begin
			data_r <= mem_rdata;
		end
	end

	// Control register
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			write_enable_latch_r  <= 1'b0;
			wr_r    <= 1'b0;
			wrerr_r <= 1'b0;
		end
		else
		begin
			if (req.wr && hit(req.addr, ndb_pkg::OFS_NVM_CTRL))
			begin
				// Only software moves the latch; a running write ignores it
				write_enable_latch_r <= req.wdata[ndb_pkg::CTRL_WRITE_ENABLE_LATCH_BIT];
			end
			if (start)
			begin
				wr_r <= 1'b1;
			end
			else if (wr_done)
			begin
				wr_r <= 1'b0;
			end
			if (wr_set_req && !start && !wr_r)
			begin
				wrerr_r <= 1'b1;
			end
			else if (req.wr && hit(req.addr, ndb_pkg::OFS_NVM_CTRL)
				&& !req.wdata[ndb_pkg::CTRL_WRERR_BIT])
			begin
				wrerr_r <= 1'b0;
			end
		end
	end

	// Flags: done flag set by hardware wins over a clear in the same cycle
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			done_flag_r   <= ndb_pkg::FLAGS_RESET[ndb_pkg::FLAG_DONE_BIT];
			other_flags_r <= ndb_pkg::FLAGS_RESET[6:0];
			irq_en_r      <= ndb_pkg::IRQ_EN_RESET;
		end
		else
		begin
			if (wr_done)
			begin
				done_flag_r <= 1'b1;
			end
			else if ((req.wr && hit(req.addr, ndb_pkg::OFS_FLAGS)
				&& !req.wdata[ndb_pkg::FLAG_DONE_BIT])
				|| (req.rd && hit(req.addr, ndb_pkg::OFS_FLAGS)))
			begin
				done_flag_r <= 1'b0;
			end
			if (req.wr && hit(req.addr, ndb_pkg::OFS_FLAGS))
			begin
				other_flags_r <= req.wdata[6:0] & ndb_pkg::FLAGS_IMPL[6:0];
			end
			if (req.wr && hit(req.addr, ndb_pkg::OFS_IRQ_EN))
			begin
				irq_en_r <= req.wdata & ndb_pkg::FLAGS_IMPL;
			end
		end
	end

	always_comb
	begin
		ctrl_view = 8'h00;
		ctrl_view[ndb_pkg::CTRL_WR_BIT]    = wr_r;
		ctrl_view[ndb_pkg::CTRL_WRITE_ENABLE_LATCH_BIT]  = write_enable_latch_r;
		ctrl_view[ndb_pkg::CTRL_WRERR_BIT] = wrerr_r;
		rd_nxt = 8'h00;
		case (req.addr)
			ndb_pkg::OFS_FLAGS:    rd_nxt = {done_flag_r, other_flags_r};
			ndb_pkg::OFS_IRQ_EN:   rd_nxt = irq_en_r;
			ndb_pkg::OFS_NVM_DATA: rd_nxt = data_r;
			ndb_pkg::OFS_NVM_ADDR: rd_nxt = addr_r;
			ndb_pkg::OFS_NVM_CTRL: rd_nxt = ctrl_view;
			ndb_pkg::OFS_STATUS:   rd_nxt = {6'h00, pwrt_busy, wr_busy};
			default:               rd_nxt = 8'h00;
		endcase
	end

	// Unlock register always reads zero; unmapped reads give zero
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			reg_rdata_out <= 8'h00;
		end
		else
		begin
			reg_rdata_out <= req.rd ? rd_nxt : 8'h00;
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			irq_out        <= 1'b0;
			write_busy_out <= 1'b0;
		end
		else
		begin
			irq_out        <= |({done_flag_r, other_flags_r} & irq_en_r);
			write_busy_out <= wr_r;
		end
	end
endmodule // ndb_nvm_access

//--- testbench/ndb_nvm_access_properties.sv
// Port-level assertions for the data NVM byte access controller
module ndb_nvm_access_properties #(
	parameter int unsigned PWRT_CYCLES  = 20,
	parameter int unsigned WRITE_CYCLES = 10
) (
	input wire logic       ref_clk_in,
	input wire logic       rst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic       reg_wr_in,
	input wire logic       reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic       irq_out,
	input wire logic       write_busy_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] up_r;
	logic [31:0] bsy_r;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	// Saturates so a long run cannot wrap back into the lockout window
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			up_r <= 32'h0;
		else if (up_r != 32'hffff_ffff)
			up_r <= up_r + 32'h1;
	end
	always_ff @(posedge ref_clk_in)
	begin
		if (!write_busy_out)
			bsy_r <= 32'h0;
		else
			bsy_r <= bsy_r + 32'h1;
	end
	rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
		else $error("read data outside read slot");
	start_cause_a: assert property ($rose(write_busy_out) |-> $past(reg_wr_in, 2)
		&& $past(reg_addr_in, 2) == ndb_pkg::OFS_NVM_CTRL && $past(reg_wdata_in[2:1], 2) == 2'h3)
		else $error("write started without control write");
	unlock_keys_a: assert property ($rose(write_busy_out) |-> $past(reg_wdata_in, 3)
		== ndb_pkg::UNLOCK_KEY2 && $past(reg_wdata_in, 5) == ndb_pkg::UNLOCK_KEY1 && !$past(reg_wr_in, 4))
		else $error("write started without exact unlock");
	// The write bit stands one cycle longer than the timer runs: it drops on the done pulse
	write_len_a: assert property ($fell(write_busy_out) |-> bsy_r == WRITE_CYCLES + 1)
		else $error("write cycle length wrong");
	// Earliest start is one cycle after the lockout ends, seen two cycles later
	pwr_lockout_a: assert property ($rose(write_busy_out) |-> up_r >= PWRT_CYCLES + 3)
		else $error("write during power-up lockout");
	busy_read_a: assert property ($past(reg_rd_in) && write_busy_out
		&& $past(reg_addr_in) == ndb_pkg::OFS_NVM_CTRL && $past(write_busy_out)
		|-> reg_rdata_out[1])
		else $error("write bit not one while busy");
	irq_rise_a: assert property ($rose(irq_out) |-> $fell(write_busy_out) || $past(reg_wr_in, 2))
		else $error("interrupt without completion");
	irq_fall_a: assert property ($fell(irq_out) |-> $past(reg_rd_in, 2) || $past(reg_wr_in, 2))
		else $error("done flag cleared by hardware");
	c_done: cover property ($fell(write_busy_out));
	c_irq: cover property ($rose(irq_out));
	c_busy_rd: cover property ($past(reg_rd_in) && write_busy_out);
endmodule // ndb_nvm_access_properties

bind ndb_nvm_access ndb_nvm_access_properties #(.PWRT_CYCLES(PWRT_CYCLES),
	.WRITE_CYCLES(WRITE_CYCLES)) u_ndb_nvm_access_properties (.ref_clk_in, .rst_n_in,
	.reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_out,
	.write_busy_out);

//--- testbench/test_ndb_nvm_access.sv
// Register-level testbench for the data NVM byte access controller
module test_ndb_nvm_access;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [7:0] rdata;
	logic       irq;
	logic       busy;
	logic [7:0] q;
	int         err_count = 0;
	int         checked = 0;
	int         cyc_n = 0;
	ndb_nvm_access #(.PWRT_CYCLES(20), .WRITE_CYCLES(10)) u_ndb_nvm_access (
		.ref_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .irq_out(irq),
		.write_busy_out(busy));
	always #50 clk = ~clk;
	task end_of_test;
		if (err_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Generous ceiling: the whole sequence needs under 150 cycles
	always @(posedge clk)
	begin
		cyc_n++;
		if (cyc_n > 2000)
		begin
			err_count++;
			end_of_test();
		end
	end
	task chk(input string n, input logic [7:0] e, input logic [7:0] s);
		checked++;
		if (s !== e)
		begin
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
			err_count++;
		end
	endtask
	task cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
	endtask
	task idle;
		cyc(1'b0, 1'b0, addr, wdata);
	endtask
	task w(input logic [7:0] a, input logic [7:0] d);
		cyc(1'b1, 1'b0, a, d);
	endtask
	task rg(input logic [7:0] a);
		cyc(1'b0, 1'b1, a, 8'h00);
		idle();
		@(negedge clk) q = rdata;
	endtask
	task go(input logic [7:0] k1, input logic [7:0] k2, input int g, input logic e);
		w(ndb_pkg::OFS_UNLOCK, k1);
		repeat (g) idle();
		w(ndb_pkg::OFS_UNLOCK, k2);
		w(ndb_pkg::OFS_NVM_CTRL, 8'h06);
		repeat (3) idle();
		@(negedge clk) chk("busy", {7'h0, e}, {7'h0, busy});
	endtask
	task fin;
		// Busy is looked at on the falling edge, where it has settled
		for (int i = 0; i < 30 && busy !== 1'b0; i++)
		begin
			idle();
			@(negedge clk);
		end
		repeat (2) idle();
		@(negedge clk) chk("irq", 8'h01, {7'h0, irq});
	endtask
	task ld(input logic [7:0] a, input logic [7:0] d);
		w(ndb_pkg::OFS_NVM_ADDR, a);
		w(ndb_pkg::OFS_NVM_DATA, d);
		w(ndb_pkg::OFS_NVM_CTRL, 8'h04);
	endtask
	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rg(ndb_pkg::OFS_FLAGS);
		chk("flags", 8'h00, q);
		rg(ndb_pkg::OFS_IRQ_EN);
		chk("irq_en", 8'h00, q);
		rg(ndb_pkg::OFS_NVM_CTRL);
		chk("ctrl", 8'h00, q);
		rg(8'h00);
		chk("unmapped", 8'h00, q);
		rg(ndb_pkg::OFS_STATUS);
		chk("status", 8'h02, q);
		w(ndb_pkg::OFS_IRQ_EN, 8'h80);
		ld(8'h05, 8'ha5);
		go(8'h55, 8'haa, 1, 1'b0);
		rg(ndb_pkg::OFS_NVM_CTRL);
		chk("ctrl_err", 8'h0c, q);
		repeat (25) idle();
		go(8'h55, 8'haa, 1, 1'b1);
		w(ndb_pkg::OFS_NVM_CTRL, 8'h00);
		rg(ndb_pkg::OFS_NVM_CTRL);
		chk("wr_bit", 8'h01, {7'h0, q[1]});
		fin();
		rg(ndb_pkg::OFS_FLAGS);
		chk("flags", 8'h80, q);
		repeat (2) idle();
		@(negedge clk) chk("irq", 8'h00, {7'h0, irq});
		w(ndb_pkg::OFS_NVM_DATA, 8'h3c);
		w(ndb_pkg::OFS_NVM_CTRL, 8'h01);
		rg(ndb_pkg::OFS_NVM_DATA);
		chk("rdata", 8'ha5, q);
		rg(ndb_pkg::OFS_NVM_DATA);
		chk("hold", 8'ha5, q);
		ld(8'h06, 8'h5a);
		go(8'h55, 8'haa, 1, 1'b1);
		fin();
		rg(ndb_pkg::OFS_NVM_CTRL);
		chk("write_enable_latch", 8'h01, {7'h0, q[2]});
		rg(ndb_pkg::OFS_FLAGS);
		chk("flags", 8'h80, q);
		w(ndb_pkg::OFS_NVM_CTRL, 8'h00);
		go(8'h55, 8'haa, 1, 1'b0);
		w(ndb_pkg::OFS_NVM_CTRL, 8'h04);
		go(8'h55, 8'haa, 2, 1'b0);
		go(8'haa, 8'h55, 1, 1'b0);
		w(ndb_pkg::OFS_NVM_DATA, 8'h00);
		w(ndb_pkg::OFS_NVM_CTRL, 8'h01);
		rg(ndb_pkg::OFS_NVM_DATA);
		chk("rdata", 8'h5a, q);
		end_of_test();
	end
endmodule // test_ndb_nvm_access
